// >>> common/wdfs_pkg.sv
/*
 Shared constants for the keyed-feed watchdog: register byte offsets,
 control field positions, reset values and feed keys.
 Assumes a 32-bit APB register bus with word-aligned registers.
*/
package wdfs_pkg;
	localparam logic [7:0] OFF_CONTROL      = 8'h00;
	localparam logic [7:0] OFF_AUTOLOAD     = 8'h04;
	localparam logic [7:0] OFF_FEED_FIRST   = 8'h08;
	localparam logic [7:0] OFF_FEED_SECOND  = 8'h0c;
	localparam logic [7:0] OFF_COUNT        = 8'h10;
	localparam logic [7:0] OFF_OTHER_ACCESS = 8'h14;
	localparam logic [7:0] OFF_TAP_SHADOW   = 8'h18;

	localparam int PRE_HI  = 7;
	localparam int PRE_LO  = 5;
	localparam int RUN_BIT = 2;
	localparam int TOF_BIT = 1;

	localparam int PRESCALE_W = 13;
	localparam int COUNT_W    = 8;
	localparam int TAP_BASE   = 4;

	localparam logic [2:0]  PRE_RESET    = 3'h7;
	localparam logic        RUN_RESET    = 1'b1;
	localparam logic [7:0]  AUTOLOAD_RST = 8'h00;
	localparam logic [7:0]  KEY_FIRST    = 8'ha5;
	localparam logic [7:0]  KEY_SECOND   = 8'h5a;
	localparam logic [12:0] PRESCALE_CLR = 13'h0000;
	localparam logic [7:0]  COUNT_ZERO   = 8'h00;
	localparam logic [31:0] READ_ZERO    = 32'h0000_0000;
	localparam int          RST_PULSE_CYCLES = 4;
	localparam logic [2:0]  RST_PULSE_LOAD   = 3'h4;
	localparam logic [2:0]  RST_PULSE_NONE   = 3'h0;
endpackage

// >>> logic/wdfs_tick_div.sv
/*
 Timer tick divider: turns the system clock into a one-cycle tick pulse.
 Assumes the timer tick rate is a fixed division of mclk_in.
*/
`timescale 1ns/100ps
module wdfs_tick_div #(
	parameter int DIV = 4
) (
	input  wire logic mclk_in,
	input  wire logic rstn_in,
	output logic      tick_out
);
	localparam int CW = $clog2(DIV) + 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] ZERO = '0;
	localparam logic [CW-1:0] ONE  = CW'(1);

	logic [CW-1:0] cnt;

	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			cnt      <= ZERO;
			tick_out <= 1'b0;
		end
		else
		begin
			tick_out <= (cnt == LAST);
			cnt      <= (cnt == LAST) ? ZERO : cnt + ONE;
		end
	end
endmodule // wdfs_tick_div

// >>> logic/wdfs_watchdog.sv
/*
 Keyed-feed watchdog: 13-bit prescaler, 8-bit down counter, pending
 control settings applied by a two-write feed, and a reset request.
 Assumes an APB master; any access other than the second key between
 the two feed keys is reported by other_access_in or a bus access.
*/
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
// Summary of operation
// - watchdog runs after external reset
// - 13-bit prescaler feeds 8-bit down counter
// - counter steps on selected upper prescaler tap
// - prescaler counts shared timer tick clock
// - fastest step every 32 ticks
// - zero plus step gives underflow and reload
// - autoload 0..ffh, prescaler cleared on autoload
// - counter loaded only from autoload register
// - a5h then 5ah consecutive writes feed
// - other access between keys forces reset
// - wrong second key forces reset
// - control writes pend until valid feed
// - select code 0..7 divides 32..4096
// - reset values give running 4096-tick timeout
// - external reset initialises all watchdog state
// - external reset wins over coinciding underflow
// - zero control plus feed stops counting
// - underflow sets flag, keeps settings, resets
// - timeout flag readable, cleared by software
// - select bits 7..5, run 2, flag 1
module wdfs_watchdog #(
	parameter int TICK_DIV = 4
) (
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic        other_access_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic             sys_reset_out,
	output logic             underflow_out
);
	logic [2:0]  pre_sel;
	logic        run;
	logic        tof;
	logic [2:0]  pend_pre;
	logic        pend_run;
	logic [7:0]  autoload;
	logic [12:0] prescale;
	logic [7:0]  count;
	logic        armed;
	logic        tick;
	logic        tap_prev;
	logic [2:0]  rst_cnt;

	wire logic acc  = psel_in && penable_in;
	wire logic wr   = acc && pwrite_in;
	wire logic rd   = acc && !pwrite_in;
	wire logic [7:0] wbyte = pwdata_in[7:0];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic known(input logic [7:0] a);
		known = hit(a, wdfs_pkg::OFF_CONTROL) ||
			hit(a, wdfs_pkg::OFF_AUTOLOAD) ||
			hit(a, wdfs_pkg::OFF_FEED_FIRST) ||
			hit(a, wdfs_pkg::OFF_FEED_SECOND) ||
			hit(a, wdfs_pkg::OFF_COUNT);
	endfunction

	// code 0 gives one step per 32 ticks
	// each code step doubles the divisor
	// tap index for select code; code 0 is bit 4 so 32 ticks per step
	function automatic logic tap_of(input logic [12:0] p,
		input logic [2:0] sel);
		tap_of = p[wdfs_pkg::TAP_BASE + int'(sel)];
	endfunction

	wdfs_tick_div #(
		.DIV (TICK_DIV)
	) u_tick (
		.mclk_in  (mclk_in),
		.rstn_in  (rstn_in),
		.tick_out (tick)
	);

	wire logic feed_first_ok  = wr && hit(paddr_in, wdfs_pkg::OFF_FEED_FIRST)
		&& (wbyte == wdfs_pkg::KEY_FIRST);
	wire logic second_wr = wr && hit(paddr_in, wdfs_pkg::OFF_FEED_SECOND);
	wire logic feed_done = armed && second_wr
		&& (wbyte == wdfs_pkg::KEY_SECOND);
	wire logic bad_second = armed && second_wr
		&& (wbyte != wdfs_pkg::KEY_SECOND);
	wire logic intrude = armed && ((acc && !second_wr) || other_access_in);
	wire logic fault = bad_second || intrude;

	// divisor 32 uses bit 4 falling edges: each tap bit n falls every 2^(n+1) ticks
	wire logic tap_now = tap_of(prescale, pre_sel);
	wire logic step = run && tap_prev && !tap_now;
	wire logic uflow = step && (count == wdfs_pkg::COUNT_ZERO);
	wire logic autoload_ev = uflow || feed_done;

	// arm on exact first key, consume on next access
	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
			armed <= 1'b0;
		else if (acc)
			// wrong first key leaves sequence idle
			armed <= feed_first_ok;
		else if (other_access_in)
			armed <= 1'b0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			pend_pre <= wdfs_pkg::PRE_RESET;
			pend_run <= wdfs_pkg::RUN_RESET;
		end
		else if (wr && hit(paddr_in, wdfs_pkg::OFF_CONTROL))
		begin
			pend_pre <= wbyte[wdfs_pkg::PRE_HI:wdfs_pkg::PRE_LO];
			pend_run <= wbyte[wdfs_pkg::RUN_BIT];
		end
	end

	// applied only by a valid feed
	// a cleared run bit stops the counter
	// run and top tap after reset
	// reset values give the 4096 divisor timeout
	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			pre_sel <= wdfs_pkg::PRE_RESET;
			run     <= wdfs_pkg::RUN_RESET;
		end
		else if (feed_done)
		begin
			pre_sel <= pend_pre;
			run     <= pend_run;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
			autoload <= wdfs_pkg::AUTOLOAD_RST;
		else if (wr && hit(paddr_in, wdfs_pkg::OFF_AUTOLOAD))
			autoload <= wbyte;
	end

	// flag survives the watchdog reset, software write of 0 clears
	// external reset clears regardless of underflow
	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
			tof <= 1'b0;
		else if (uflow)
			// set wins over a same-cycle clear
			tof <= 1'b1;
		else if (wr && hit(paddr_in, wdfs_pkg::OFF_CONTROL)
			&& !wbyte[wdfs_pkg::TOF_BIT])
			tof <= 1'b0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			prescale <= wdfs_pkg::PRESCALE_CLR;
			tap_prev <= 1'b0;
		end
		else if (autoload_ev)
		begin
			prescale <= wdfs_pkg::PRESCALE_CLR;
			tap_prev <= 1'b0;
		end
		else
		begin
			tap_prev <= tap_now;
			if (tick && run)
				prescale <= prescale + 13'h0001;
		end
	end

	// only autoload value ever loads the counter
	// reset performs an autoload of 00
	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
			count <= wdfs_pkg::AUTOLOAD_RST;
		else if (autoload_ev)
			count <= autoload;
		else if (step)
			count <= count - 8'h01;
	end

	// underflow or feed fault requests a system reset pulse
	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			rst_cnt       <= wdfs_pkg::RST_PULSE_NONE;
			sys_reset_out <= 1'b0;
			underflow_out <= 1'b0;
		end
		else
		begin
			underflow_out <= uflow;
			if (uflow || fault)
				rst_cnt <= wdfs_pkg::RST_PULSE_LOAD;
			else if (rst_cnt != wdfs_pkg::RST_PULSE_NONE)
				rst_cnt <= rst_cnt - 3'h1;
			sys_reset_out <= uflow || fault
				|| (rst_cnt > 3'h1);
		end
	end

	// zero-wait slave; unmapped addresses answer with an error
	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			prdata_out  <= wdfs_pkg::READ_ZERO;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end
		else
		begin
			pready_out  <= psel_in && !penable_in;
			pslverr_out <= psel_in && !penable_in && !known(paddr_in);
			prdata_out  <= wdfs_pkg::READ_ZERO;
			if (psel_in && !penable_in && !pwrite_in)
			begin
				// select, run and flag bit positions
				if (hit(paddr_in, wdfs_pkg::OFF_CONTROL))
				begin
					prdata_out[wdfs_pkg::PRE_HI:wdfs_pkg::PRE_LO] <= pre_sel;
					prdata_out[wdfs_pkg::RUN_BIT] <= run;
					prdata_out[wdfs_pkg::TOF_BIT] <= tof;
				end
				else if (hit(paddr_in, wdfs_pkg::OFF_AUTOLOAD))
					prdata_out[7:0] <= autoload;
				else if (hit(paddr_in, wdfs_pkg::OFF_COUNT))
					prdata_out[7:0] <= count;
			end
		end
	end

	// underflow reloads the counter from autoload on the next cycle
	AST_UFLOW_ZERO: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		uflow |=> (count == $past(autoload)))
		else $error("underflow did not reload counter");

	AST_RESET_ON_UFLOW: assert property (@(posedge mclk_in)
		disable iff (!rstn_in) uflow |=> sys_reset_out [*3])
		else $error("no reset pulse after underflow");

	AST_BAD_KEY: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		bad_second |=> sys_reset_out)
		else $error("wrong second key gave no reset");

	AST_INTRUDE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(armed && acc && !second_wr) |=> sys_reset_out)
		else $error("intervening access gave no reset");

	AST_PEND: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		!feed_done |=> $stable(run) && $stable(pre_sel))
		else $error("control changed without feed");

	AST_FEED_APPLY: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		feed_done |=> (run == $past(pend_run)) && (count == $past(autoload))
			&& (prescale == wdfs_pkg::PRESCALE_CLR))
		else $error("feed did not apply settings");

	AST_STOPPED: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		!run |=> $stable(count) || $past(autoload_ev))
		else $error("counter moved while stopped");

	AST_ARM_KEY: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(wr && hit(paddr_in, wdfs_pkg::OFF_FEED_FIRST)
			&& wbyte != wdfs_pkg::KEY_FIRST) |=> !armed)
		else $error("wrong first key armed feed");

	AST_TOF_SET: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		uflow |=> tof)
		else $error("timeout flag not set");

	AST_STEP_ONE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(step && !autoload_ev) |=> count == $past(count) - 8'h01)
		else $error("counter step wrong");
endmodule // wdfs_watchdog

// >>> sim/wdfs_watchdog_tb_top.sv
/*
 Self-checking bench for the keyed-feed watchdog: APB register tasks,
 feed faults, timeout, stop and reset values.
 Assumes the design answers APB with pready and needs no other model.
*/
`timescale 1ns/100ps
module wdfs_watchdog_tb_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        oth = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sysrst;
	logic        unf;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          t0;
	int          k;
	logic        seen;
	logic [31:0] r;
	logic [31:0] c1;

	// one tick per clock keeps the 32-tick step short
	wdfs_watchdog #(.TICK_DIV(1)) i_wdfs_watchdog (
		.mclk_in         (clk),
		.rstn_in         (rstn),
		.psel_in         (psel),
		.penable_in      (pen),
		.pwrite_in       (pwr),
		.paddr_in        (paddr),
		.pwdata_in       (pwdata),
		.other_access_in (oth),
		.prdata_out      (prdata),
		.pready_out      (pready),
		.pslverr_out     (pslverr),
		.sys_reset_out   (sysrst),
		.underflow_out   (unf)
	);

	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	task give_verdict;
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic err);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (i >= 20)
		begin
			n_fail++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, d, x, e);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v);
		logic e;
		apb(1'b0, a, 8'h00, v, e);
	endtask

	task feed;
		wr(wdfs_pkg::OFF_FEED_FIRST, wdfs_pkg::KEY_FIRST);
		wr(wdfs_pkg::OFF_FEED_SECOND, wdfs_pkg::KEY_SECOND);
	endtask

	// watch the reset request for a few cycles, then let its pulse end
	task watch_rst(output logic s);
		s = 1'b0;
		repeat (8)
		begin
			@(posedge clk);
			s = s | (sysrst === 1'b1);
		end
		repeat (8) @(posedge clk);
	endtask

	task pwr_on;
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
	endtask

	initial
	begin
		pwr_on();
		rd(wdfs_pkg::OFF_CONTROL, r);
		chk(r, 32'h0000_00e4);
		rd(wdfs_pkg::OFF_AUTOLOAD, r);
		chk(r, 32'h0000_0000);
		apb(1'b0, 8'h1c, 8'h00, r, seen);
		chk({31'h0, seen}, 32'h1);
		// feed cases: wrong second key, wrong first key (no reset), bus access, other access
		for (k = 0; k < 4; k++)
		begin
			wr(wdfs_pkg::OFF_FEED_FIRST, (k == 1) ? 8'h11 : 8'ha5);
			if (k == 2)
				rd(wdfs_pkg::OFF_CONTROL, r);
			if (k == 3)
			begin
				@(posedge clk);
				oth <= 1'b1;
				@(posedge clk);
				oth <= 1'b0;
			end
			if (k < 2)
				wr(wdfs_pkg::OFF_FEED_SECOND, (k == 0) ? 8'h11 : 8'h5a);
			watch_rst(seen);
			chk({31'h0, seen}, {31'h0, k != 1});
		end
		wr(wdfs_pkg::OFF_CONTROL, 8'h04);
		rd(wdfs_pkg::OFF_CONTROL, r);
		chk(r, 32'h0000_00e4);
		wr(wdfs_pkg::OFF_AUTOLOAD, 8'h03);
		feed();
		t0 = cyc;
		rd(wdfs_pkg::OFF_CONTROL, r);
		chk(r, 32'h0000_0004);
		wr(wdfs_pkg::OFF_COUNT, 8'h55);
		rd(wdfs_pkg::OFF_COUNT, r);
		chk(r, 32'h0000_0003);
		while (unf !== 1'b1 && cyc - t0 < 400)
			@(posedge clk);
		// four steps of 32 ticks plus a few cycles of pipeline
		chk({31'h0, (cyc - t0 >= 124) && (cyc - t0 <= 136)}, 32'h1);
		watch_rst(seen);
		chk({31'h0, seen}, 32'h1);
		rd(wdfs_pkg::OFF_COUNT, r);
		chk(r, 32'h0000_0003);
		rd(wdfs_pkg::OFF_CONTROL, r);
		chk(r, 32'h0000_0006);
		wr(wdfs_pkg::OFF_CONTROL, 8'h04);
		rd(wdfs_pkg::OFF_CONTROL, r);
		chk(r, 32'h0000_0004);
		wr(wdfs_pkg::OFF_CONTROL, 8'h00);
		feed();
		rd(wdfs_pkg::OFF_COUNT, c1);
		seen = 1'b0;
		repeat (300)
		begin
			@(posedge clk);
			seen = seen | (unf === 1'b1);
		end
		rd(wdfs_pkg::OFF_COUNT, r);
		chk(r, c1);
		chk({31'h0, seen}, 32'h0);
		pwr_on();
		rd(wdfs_pkg::OFF_CONTROL, r);
		chk(r, 32'h0000_00e4);
		rd(wdfs_pkg::OFF_COUNT, r);
		chk(r, 32'h0000_0000);
		give_verdict();
	end
endmodule // wdfs_watchdog_tb_top
